// *** src/gpb_bank.v ***
// global parameter bank: banks 0..3 behind a parameter command port
// assumes same-clock command source, program engine and nv controller
// Operation
// - protection accepts codes 0 none,1 readback,2 overwrite,3 both
// - clearing readback guard erases stored program before new setting
// - coordinate storage 1 mirrors each coordinate write to nonvolatile
// - startup restores user variables unless no-restore flag is 1
// - second bus address 1..255 answered; 0 disables it
// - reverse flag inverts motor and encoder, normal mode only
// - read-only run state: 0 stop,1 run,2 step,3 reset
// - program counter parameter returns executing command address
// - 32-bit millisecond counter, loadable by write
// - random read gives 1..2^31-1; write loads seed
// - mute flag 1 suppresses direct-mode replies
// - mute flag never stored, cleared at every startup
// - get axis, get global, get input always replied
// - bank 2: 256 signed 32-bit variables, 0..55 storable
// - after boot stored variables copied back to volatile store
// - lower interrupt number has higher priority
// - three periodic timers, period in ms, 32-bit
// - edge select: 0 off,1 rising,2 falling,3 both
// - edge interrupts for stop switches and inputs 0..3
// - bank 1 absent, reserved for extensions
`include "gpb_map.vh"
`timescale 1ns/10ps
`default_nettype none
module gpb_bank #(
  parameter TICK_CYCLES = `GPB_CLK_KHZ * `GPB_TICK_US / 1000
) (
  input wire core_clk,
  input wire rst_n,
  input wire cmd_valid,
  input wire cmd_write,
  input wire cmd_store,
  input wire cmd_direct,
  input wire cmd_is_get,
  input wire [7:0] cmd_bank,
  input wire [7:0] cmd_param,
  input wire [31:0] cmd_wdata,
  output reg cmd_ready_r,
  output reg rsp_valid_r,
  output reg rsp_err_r,
  output reg rsp_send_r,
  output reg [31:0] rsp_rdata_r,
  input wire [1:0] run_state_in,
  input wire load_state_in,
  input wire [31:0] prog_pc_in,
  input wire stepdir_mode,
  input wire coord_wr_evt,
  input wire nv_skip_restore,
  input wire nv_rd_valid,
  input wire [31:0] nv_rd_data,
  output reg nv_rd_req_r,
  output reg [7:0] nv_rd_idx_r,
  output reg nv_wr_req_r,
  output reg [7:0] nv_wr_idx_r,
  output reg [31:0] nv_wr_data_r,
  output reg nv_coord_wr_r,
  output reg erase_req_r,
  output reg [1:0] prot_r,
  output reg coord_persist_r,
  output reg skip_restore_r,
  output reg [7:0] addr2_r,
  output reg addr2_en_r,
  output reg dir_invert_r,
  input wire stop_left_pin,
  input wire stop_right_pin,
  input wire [3:0] gp_in_pin,
  input wire irq_ack,
  output reg irq_valid_r,
  output reg [7:0] irq_num_r
);
  localparam NSRC = 9;
  localparam S_INIT = 4'h1;
  localparam S_RD = 4'h2;
  localparam S_WAIT = 4'h4;
  localparam S_RUN = 4'h8;
  localparam [15:0] TICK_MAX = TICK_CYCLES - 1;

  reg [3:0] st_r;
  reg [7:0] ridx_r;
  reg mute_r;
  reg reverse_r;
  reg [31:0] tick_r;
  reg [30:0] lfsr_r;
  reg [15:0] div_r;
  reg ms_en_r;
  reg [95:0] per_r;
  reg [11:0] esel_r;
  reg [5:0] sy1_r;
  reg [5:0] sy2_r;
  reg [5:0] prev_r;
  reg [NSRC-1:0] pend_r;
  reg [3:0] sidx_r;
  reg p_valid_r;
  reg p_mem_r;
  reg p_err_r;
  reg p_send_r;
  reg [31:0] p_rdata_r;
  wire [31:0] mem_q;
  wire [NSRC-1:0] fire;
  wire take = cmd_valid & cmd_ready_r;
  wire b_main = (cmd_bank == `GPB_BANK_MAIN);
  wire b_uvar = (cmd_bank == `GPB_BANK_UVAR);
  wire b_irq = (cmd_bank == `GPB_BANK_IRQ);
  wire in_edges = (cmd_param >= `GPB_P_IN0) && (cmd_param <= `GPB_P_IN3);
  wire [7:0] in_off = cmd_param - `GPB_P_IN0;

  ////////////////////////////////////////////////////////////////////////
  // startup: catch no-restore flag, then copy nv variables back
  // restore unless skipped
  always @(posedge core_clk) begin
    if (!rst_n) begin
      st_r <= S_INIT;
      ridx_r <= 8'h00;
      nv_rd_req_r <= 1'b0;
      nv_rd_idx_r <= 8'h00;
      skip_restore_r <= 1'b0;
    end else begin
      nv_rd_req_r <= 1'b0;
      case (st_r)
        S_INIT: begin
          skip_restore_r <= nv_skip_restore;
          st_r <= nv_skip_restore ? S_RUN : S_RD;
        end
        S_RD: begin
          nv_rd_req_r <= 1'b1;
          nv_rd_idx_r <= ridx_r;
          st_r <= S_WAIT;
        end
        S_WAIT: begin
          if (nv_rd_valid) begin
            ridx_r <= ridx_r + 8'h01;
            st_r <= (ridx_r == `GPB_UVAR_NV - 8'h01) ? S_RUN : S_RD;
          end
        end
        S_RUN: begin
          if (take && cmd_write && b_main && cmd_param == `GPB_P_NORESTORE) begin
            skip_restore_r <= cmd_wdata[0];
          end
        end
        default: st_r <= S_INIT;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // user variable store, shared by restore and commands
  // 256 variables in volatile store
  wire rst_wr = (st_r == S_WAIT) & nv_rd_valid;
  wire cmd_mwr = take & cmd_write & b_uvar;

  gpb_uvar_mem #(
    .WIDTH(32),
    .DEPTH(`GPB_UVAR_DEPTH),
    .AW(8)
  ) u_mem (
    .core_clk(core_clk),
    .wr_en(rst_wr | cmd_mwr),
    .wr_addr(rst_wr ? ridx_r : cmd_param),
    .wr_data(rst_wr ? nv_rd_data : cmd_wdata),
    .rd_addr(cmd_param),
    .rd_data_r(mem_q)
  );

  ////////////////////////////////////////////////////////////////////////
  // command decode: error, reply and read data for each request
  reg dec_err;
  reg [31:0] dec_rd;
  always @* begin
    dec_err = 1'b0;
    dec_rd = 32'h00000000;
    if (b_main) begin
      case (cmd_param)
        `GPB_P_PROT: dec_rd = {30'h0, prot_r};
        `GPB_P_COORD: dec_rd = {31'h0, coord_persist_r};
        `GPB_P_NORESTORE: dec_rd = {31'h0, skip_restore_r};
        `GPB_P_ADDR2: dec_rd = {24'h0, addr2_r};
        `GPB_P_REVERSE: dec_rd = {31'h0, reverse_r};
        `GPB_P_RUNSTATE: begin
          dec_rd = {30'h0, run_state_in};
          dec_err = cmd_write;
        end
        `GPB_P_LOADSTATE: begin
          dec_rd = {31'h0, load_state_in};
          dec_err = cmd_write;
        end
        `GPB_P_PC: begin
          dec_rd = prog_pc_in;
          dec_err = cmd_write;
        end
        `GPB_P_TICK: dec_rd = tick_r;
        `GPB_P_RANDOM: dec_rd = {1'b0, lfsr_r};
        `GPB_P_MUTE: dec_rd = {31'h0, mute_r};
        default: dec_err = 1'b1;
      endcase
      if (cmd_store && cmd_param == `GPB_P_MUTE) begin
        dec_err = 1'b1;
      end
    end else if (b_irq) begin
      if (cmd_param <= `GPB_P_TMR2) begin
        dec_rd = per_r[cmd_param[1:0]*32 +: 32];
      end else if (cmd_param == `GPB_P_STOPL) begin
        dec_rd = {30'h0, esel_r[1:0]};
      end else if (cmd_param == `GPB_P_STOPR) begin
        dec_rd = {30'h0, esel_r[3:2]};
      end else if (in_edges) begin
        dec_rd = {30'h0, esel_r[in_off[1:0]*2+4 +: 2]};
      end else begin
        dec_err = 1'b1;
      end
    end else if (b_uvar) begin
      dec_err = cmd_store && (cmd_param >= `GPB_UVAR_NV);
    end else begin
      dec_err = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // two-stage reply pipeline, one request per cycle
  always @(posedge core_clk) begin
    if (!rst_n) begin
      cmd_ready_r <= 1'b0;
      p_valid_r <= 1'b0;
      p_mem_r <= 1'b0;
      p_err_r <= 1'b0;
      p_send_r <= 1'b0;
      p_rdata_r <= 32'h00000000;
      rsp_valid_r <= 1'b0;
      rsp_err_r <= 1'b0;
      rsp_send_r <= 1'b0;
      rsp_rdata_r <= 32'h00000000;
    end else begin
      cmd_ready_r <= (st_r == S_RUN);
      p_valid_r <= take;
      p_mem_r <= b_uvar;
      p_err_r <= dec_err;
      p_send_r <= take & ~(mute_r & cmd_direct & ~cmd_is_get);
      p_rdata_r <= dec_rd;
      rsp_valid_r <= p_valid_r;
      rsp_err_r <= p_valid_r & p_err_r;
      rsp_send_r <= p_send_r;
      rsp_rdata_r <= p_mem_r ? mem_q : p_rdata_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bank 0 settings and their outputs
  wire wr0 = take & cmd_write & b_main;
  always @(posedge core_clk) begin
    if (!rst_n) begin
      prot_r <= `GPB_RST_PROT;
      erase_req_r <= 1'b0;
      coord_persist_r <= 1'b0;
      addr2_r <= `GPB_RST_ADDR2;
      addr2_en_r <= 1'b0;
      reverse_r <= 1'b0;
      dir_invert_r <= 1'b0;
      mute_r <= 1'b0;
      nv_coord_wr_r <= 1'b0;
    end else begin
      erase_req_r <= 1'b0;
      if (wr0 && cmd_param == `GPB_P_PROT) begin
        prot_r <= cmd_wdata[1:0];
        erase_req_r <= prot_r[`GPB_PROT_RDGUARD] &
          ~cmd_wdata[`GPB_PROT_RDGUARD];
      end
      if (wr0 && cmd_param == `GPB_P_COORD) begin
        coord_persist_r <= cmd_wdata[0];
      end
      nv_coord_wr_r <= coord_wr_evt & coord_persist_r;
      if (wr0 && cmd_param == `GPB_P_ADDR2) begin
        addr2_r <= cmd_wdata[7:0];
        addr2_en_r <= (cmd_wdata[7:0] != 8'h00);
      end
      if (wr0 && cmd_param == `GPB_P_REVERSE) begin
        reverse_r <= cmd_wdata[0];
      end
      dir_invert_r <= reverse_r & ~stepdir_mode;
      if (wr0 && cmd_param == `GPB_P_MUTE) begin
        mute_r <= cmd_wdata[0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // store requests towards the nv controller
  always @(posedge core_clk) begin
    if (!rst_n) begin
      nv_wr_req_r <= 1'b0;
      nv_wr_idx_r <= 8'h00;
      nv_wr_data_r <= 32'h00000000;
    end else begin
      nv_wr_req_r <= take & cmd_store & b_uvar &
        (cmd_param < `GPB_UVAR_NV);
      nv_wr_idx_r <= cmd_param;
      nv_wr_data_r <= cmd_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // millisecond enable, tick counter, random source
  always @(posedge core_clk) begin
    if (!rst_n) begin
      div_r <= 16'h0000;
      ms_en_r <= 1'b0;
      tick_r <= 32'h00000000;
      lfsr_r <= `GPB_RST_SEED;
    end else begin
      ms_en_r <= (div_r == TICK_MAX);
      div_r <= (div_r == TICK_MAX) ? 16'h0000 : div_r + 16'h0001;
      if (wr0 && cmd_param == `GPB_P_TICK) begin
        tick_r <= cmd_wdata;
      end else if (ms_en_r) begin
        tick_r <= tick_r + 32'h00000001;
      end
      if (wr0 && cmd_param == `GPB_P_RANDOM) begin
        lfsr_r <= (cmd_wdata[30:0] == 31'h0) ? `GPB_RST_SEED
          : cmd_wdata[30:0];
      end else begin
        lfsr_r <= {lfsr_r[29:0], lfsr_r[30] ^ lfsr_r[27]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bank 3 configuration
  // set through bank 3 writes
  wire wr3 = take & cmd_write & b_irq;
  always @(posedge core_clk) begin
    if (!rst_n) begin
      per_r <= {3{`GPB_RST_PERIOD}};
      esel_r <= {6{`GPB_RST_EDGE}};
    end else if (wr3) begin
      if (cmd_param <= `GPB_P_TMR2) begin
        per_r[cmd_param[1:0]*32 +: 32] <= cmd_wdata;
      end
      if (cmd_param == `GPB_P_STOPL) begin
        esel_r[1:0] <= cmd_wdata[1:0];
      end
      if (cmd_param == `GPB_P_STOPR) begin
        esel_r[3:2] <= cmd_wdata[1:0];
      end
      if (in_edges) begin
        esel_r[in_off[1:0]*2+4 +: 2] <= cmd_wdata[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge history
  always @(posedge core_clk) begin
    if (!rst_n) begin
      sy1_r <= 6'h00;
      sy2_r <= 6'h00;
      prev_r <= 6'h00;
    end else begin
      sy1_r <= {gp_in_pin, stop_right_pin, stop_left_pin};
      sy2_r <= sy1_r;
      prev_r <= sy2_r;
    end
  end

  // periodic timers, period zero is off
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_tmr
      reg [31:0] cnt_r;
      wire [31:0] per = per_r[g*32 +: 32];
      wire hit = ms_en_r && (per != 32'h0) && (cnt_r >= per - 32'h1);
      always @(posedge core_clk) begin
        if (!rst_n) begin
          cnt_r <= 32'h00000000;
        end else if (per == 32'h0 || hit) begin
          cnt_r <= 32'h00000000;
        end else if (ms_en_r) begin
          cnt_r <= cnt_r + 32'h00000001;
        end
      end
      assign fire[g] = hit;
    end
    for (g = 0; g < 6; g = g + 1) begin : g_edge
      assign fire[g+3] =
        (esel_r[g*2+`GPB_EDGE_RISE] & sy2_r[g] & ~prev_r[g]) |
        (esel_r[g*2+`GPB_EDGE_FALL] & ~sy2_r[g] & prev_r[g]);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // pending sources and priority selection
  reg [3:0] win;
  reg found;
  integer k;
  always @* begin
    win = 4'h0;
    found = 1'b0;
    for (k = NSRC - 1; k >= 0; k = k - 1) begin
      if (pend_r[k]) begin
        win = k[3:0];
        found = 1'b1;
      end
    end
  end

  function [7:0] src_num;
    input [3:0] i;
    begin
      case (i)
        4'h0: src_num = `GPB_P_TMR0;
        4'h1: src_num = `GPB_P_TMR1;
        4'h2: src_num = `GPB_P_TMR2;
        4'h3: src_num = `GPB_P_STOPL;
        4'h4: src_num = `GPB_P_STOPR;
        default: src_num = `GPB_P_IN0 + {4'h0, i} - 8'h05;
      endcase
    end
  endfunction

  wire [NSRC-1:0] clr = (irq_ack & irq_valid_r) ?
    ({{(NSRC-1){1'b0}}, 1'b1} << sidx_r) : {NSRC{1'b0}};
  always @(posedge core_clk) begin
    if (!rst_n) begin
      pend_r <= {NSRC{1'b0}};
      sidx_r <= 4'h0;
      irq_valid_r <= 1'b0;
      irq_num_r <= 8'h00;
    end else begin
      pend_r <= (pend_r & ~clr) | fire;
      if (!irq_valid_r || irq_ack) begin
        irq_valid_r <= found & ~(irq_ack & (win == sidx_r));
        sidx_r <= win;
        irq_num_r <= src_num(win);
      end
    end
  end
endmodule
`default_nettype wire

// *** src/gpb_map.vh ***
// constants for the global parameter bank: banks, numbers, resets, timing
// assumes inclusion by the bank module file, ahead of the module
`ifndef GPB_MAP_VH
`define GPB_MAP_VH
// parameter banks
`define GPB_BANK_MAIN 8'h00
`define GPB_BANK_EXT 8'h01
`define GPB_BANK_UVAR 8'h02
`define GPB_BANK_IRQ 8'h03
// bank 0 parameter numbers
`define GPB_P_PROT 8'h51
`define GPB_P_COORD 8'h54
`define GPB_P_NORESTORE 8'h55
`define GPB_P_ADDR2 8'h57
`define GPB_P_REVERSE 8'h5a
`define GPB_P_RUNSTATE 8'h80
`define GPB_P_LOADSTATE 8'h81
`define GPB_P_PC 8'h82
`define GPB_P_TICK 8'h84
`define GPB_P_RANDOM 8'h85
`define GPB_P_MUTE 8'hff
// bank 3 parameter numbers
`define GPB_P_TMR0 8'h00
`define GPB_P_TMR1 8'h01
`define GPB_P_TMR2 8'h02
`define GPB_P_STOPL 8'h1b
`define GPB_P_STOPR 8'h1c
`define GPB_P_IN0 8'h27
`define GPB_P_IN3 8'h2a
// field layout
`define GPB_PROT_RDGUARD 0
`define GPB_EDGE_RISE 0
`define GPB_EDGE_FALL 1
// reset values
`define GPB_RST_PROT 2'h0
`define GPB_RST_ADDR2 8'h00
`define GPB_RST_PERIOD 32'h00000000
`define GPB_RST_EDGE 2'h0
`define GPB_RST_SEED 31'h00000001
// user variables: total and nonvolatile count
`define GPB_UVAR_DEPTH 256
`define GPB_UVAR_NV 8'h38
// tick timing
`define GPB_TICK_US 1000
`define GPB_CLK_KHZ 20000
`endif

// *** src/gpb_uvar_mem.v ***
// user variable store: one write port, registered read data
// assumes one clock, write and read in the same cycle allowed
`timescale 1ns/10ps
`default_nettype none
module gpb_uvar_mem #(
  parameter WIDTH = 32,
  parameter DEPTH = 256,
  parameter AW = 8
) (
  input wire core_clk,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [WIDTH-1:0] wr_data,
  input wire [AW-1:0] rd_addr,
  output reg [WIDTH-1:0] rd_data_r
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];

  // write port, then registered read
  always @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_r <= mem[rd_addr];
  end
endmodule
`default_nettype wire

// *** verification/gpb_nv_model.sv ***
// stand-in for the nonvolatile store behind the parameter bank
// assumes one restore read outstanding, same clock as the bank
`timescale 1ns/10ps
`default_nettype none
module gpb_nv_model (
  input wire logic core_clk, skip_in, nv_rd_req_r,
  input wire logic [7:0] nv_rd_idx_r,
  output logic nv_skip_restore, nv_rd_valid,
  output logic [31:0] nv_rd_data
);
  logic busy_r = 0;
  logic [1:0] wait_r = 0;
  logic [7:0] idx_r = 0;
  assign nv_skip_restore = skip_in;
  // idle bus before first read
  initial begin
    nv_rd_valid = 0;
    nv_rd_data = 0;
  end
  always @(posedge core_clk) begin
    nv_rd_valid <= 0;
    nv_rd_data <= ~nv_rd_data; // released data bus
    if (nv_rd_req_r === 1'b1) begin
      busy_r <= 1;
      idx_r <= nv_rd_idx_r;
      wait_r <= {nv_rd_idx_r[0], 1'b0}; // odd index answers slowly
    end else if (busy_r && wait_r != 0) begin
      wait_r <= wait_r - 1;
    end else if (busy_r) begin
      busy_r <= 0;
      nv_rd_valid <= 1;
      nv_rd_data <= 32'hc0de0000 | idx_r;
    end
  end
endmodule
`default_nettype wire

// *** verification/gpb_bank_asserts.sv ***
// checker: answer, protection, address and irq relations of the bank
// assumes bind to gpb_bank, one clock, synchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
module gpb_bank_chk (
  input wire logic core_clk, rst_n, cmd_valid, cmd_write, cmd_is_get,
  input wire logic [7:0] cmd_bank, cmd_param,
  input wire logic [31:0] cmd_wdata,
  input wire logic cmd_ready_r, rsp_valid_r, rsp_err_r, rsp_send_r,
  input wire logic erase_req_r, addr2_en_r, irq_ack, irq_valid_r,
  input wire logic [1:0] prot_r,
  input wire logic [7:0] addr2_r, irq_num_r
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // taken request and protection write
  wire tk = cmd_valid && cmd_ready_r;
  wire wr0 = tk && cmd_write && cmd_bank == 8'h00;
  wire wp = wr0 && cmd_param == 8'h51;
  wire [1:0] wlo = cmd_wdata[1:0];
  property p_get_reply;
    tk && cmd_is_get |-> ##2 rsp_valid_r && rsp_send_r;
  endproperty
  a_get_reply: assert property (p_get_reply)
    else $error("get request without reply");
  property p_bank1;
    tk && cmd_bank == 8'h01 |-> ##2 rsp_valid_r && rsp_err_r;
  endproperty
  a_bank1: assert property (p_bank1)
    else $error("bank 1 request not refused");
  property p_ro;
    wr0 && cmd_param inside {8'h80, 8'h81, 8'h82} |-> ##2 rsp_err_r;
  endproperty
  a_ro: assert property (p_ro)
    else $error("read-only write not refused");
  property p_prot;
    wp |=> prot_r == $past(wlo);
  endproperty
  a_prot: assert property (p_prot)
    else $error("protection code not taken");
  property p_erase;
    wp && prot_r[0] && !cmd_wdata[0] |=> erase_req_r;
  endproperty
  a_erase: assert property (p_erase)
    else $error("program not erased");
  property p_addr2;
    addr2_en_r == (addr2_r != 8'h00);
  endproperty
  a_addr2: assert property (p_addr2)
    else $error("second address enable wrong");
  property p_irq_hold;
    irq_valid_r && !irq_ack |=> irq_valid_r && $stable(irq_num_r);
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("irq dropped before ack");
  property p_irq_src;
    irq_valid_r |-> irq_num_r inside {[8'h00:8'h02], 8'h1b, 8'h1c,
      [8'h27:8'h2a]};
  endproperty
  a_irq_src: assert property (p_irq_src)
    else $error("irq number outside sources");
  // main scenarios reached
  c_erase: cover property (erase_req_r);
  c_ack: cover property (irq_valid_r && irq_ack);
  c_uvar: cover property (tk && cmd_bank == 8'h02);
endmodule
bind gpb_bank gpb_bank_chk chk_u (.core_clk, .rst_n, .cmd_valid,
  .cmd_write, .cmd_is_get, .cmd_bank, .cmd_param, .cmd_wdata,
  .cmd_ready_r, .rsp_valid_r, .rsp_err_r, .rsp_send_r, .erase_req_r,
  .addr2_en_r, .irq_ack, .irq_valid_r, .prot_r, .addr2_r, .irq_num_r);
`default_nettype wire

// *** verification/test_gpb_bank.sv ***
// bench: command port scenarios for the parameter bank
// assumes the nv stand-in and a 20-cycle millisecond
`timescale 1ns/10ps
`default_nettype none
module test_gpb_bank;
  localparam int TC = 20;
  logic core_clk = 0, rst_n = 0, cmd_valid = 0, cmd_write = 0;
  logic cmd_store = 0, cmd_direct = 0, cmd_is_get = 0, skip = 0;
  logic load_state_in = 1, coord_wr_evt = 0, irq_ack = 0, er, sd, ers, nws;
  logic stepdir_mode = 0, stop_left_pin = 0, stop_right_pin = 0;
  logic [1:0] run_state_in = 0;
  logic [3:0] gp_in_pin = 0;
  logic [7:0] cmd_bank = 0, cmd_param = 0, nq[$], nwi;
  logic [31:0] cmd_wdata = 0, prog_pc_in = 32'h00000123, rd, ra;
  int mismatches = 0, n_compared = 0, nreq = 0;
  wire cmd_ready_r, rsp_valid_r, rsp_err_r, rsp_send_r, erase_req_r;
  wire nv_rd_req_r, nv_rd_valid, nv_skip_restore, nv_coord_wr_r;
  wire addr2_en_r, dir_invert_r, irq_valid_r;
  wire coord_persist_r, skip_restore_r, nv_wr_req_r;
  wire [1:0] prot_r;
  wire [7:0] nv_rd_idx_r, irq_num_r, nv_wr_idx_r;
  wire [31:0] rsp_rdata_r, nv_rd_data;
  // 20 MHz clock
  always #25 core_clk = ~core_clk;
  gpb_bank #(.TICK_CYCLES(TC)) dut_u (
    .core_clk, .rst_n, .cmd_valid, .cmd_write, .cmd_store, .cmd_direct,
    .cmd_is_get, .cmd_bank, .cmd_param, .cmd_wdata, .cmd_ready_r,
    .rsp_valid_r, .rsp_err_r, .rsp_send_r, .rsp_rdata_r, .run_state_in,
    .load_state_in, .prog_pc_in, .stepdir_mode, .coord_wr_evt,
    .nv_skip_restore, .nv_rd_valid, .nv_rd_data, .nv_rd_req_r,
    .nv_rd_idx_r, .nv_wr_req_r, .nv_wr_idx_r, .nv_wr_data_r(),
    .nv_coord_wr_r, .erase_req_r, .prot_r, .coord_persist_r,
    .skip_restore_r, .addr2_r(), .addr2_en_r, .dir_invert_r,
    .stop_left_pin, .stop_right_pin, .gp_in_pin, .irq_ack,
    .irq_valid_r, .irq_num_r);
  gpb_nv_model nv_u (.core_clk, .skip_in(skip), .nv_rd_req_r,
    .nv_rd_idx_r, .nv_skip_restore, .nv_rd_valid, .nv_rd_data);
  // restore read counter
  always @(posedge core_clk) nreq += (nv_rd_req_r === 1'b1);
  task automatic cmp(string n, logic [31:0] x, logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, x, g);
    end
  endtask
  // one command; answer two edges after it is taken
  task automatic req(logic [3:0] k, logic [7:0] b, p, logic [31:0] d = 0);
    @(posedge core_clk) #1;
    {cmd_store, cmd_is_get, cmd_direct, cmd_write} = k;
    cmd_bank = b;
    cmd_param = p;
    cmd_wdata = d;
    cmd_valid = 1;
    @(posedge core_clk) #1;
    cmd_valid = 0;
    {ers, nws, nwi} = {erase_req_r, nv_wr_req_r, nv_wr_idx_r};
    @(posedge core_clk) #1;
    cmp("answer", 1, rsp_valid_r);
    {er, sd, rd} = {rsp_err_r, rsp_send_r, rsp_rdata_r};
  endtask
  task automatic wait_rdy(int lim);
    for (int i = 0; i < lim && cmd_ready_r !== 1'b1; i++)
      @(posedge core_clk) #1;
    cmp("ready", 1, cmd_ready_r);
  endtask
  // collect and ack pending irqs
  task automatic drain(int cyc);
    nq = {};
    repeat (cyc) begin
      @(posedge core_clk) #1;
      if (irq_valid_r === 1'b1 && !irq_ack) begin
        nq.push_back(irq_num_r);
        irq_ack = 1;
      end else irq_ack = 0;
    end
    @(posedge core_clk) #1 irq_ack = 0;
  endtask
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // user variables: restore, width, store limit
  task automatic t_uvar;
    wait_rdy(600);
    cmp("restore reads", 56, nreq);
    req(4'b0100, 8'h02, 8'h37);
    cmp("var55", 32'hc0de0037, rd);
    req(4'b0001, 8'h02, 8'hff, 32'h80000001);
    req(4'b0001, 8'h02, 8'hc8, 32'hfffffffe);
    req(4'b0100, 8'h02, 8'hff);
    cmp("var255", 32'h80000001, rd);
    req(4'b1000, 8'h02, 8'h38);
    cmp("store56 err", 1, er);
    cmp("store56 req", 0, nws);
    req(4'b1000, 8'h02, 8'h37);
    cmp("store55 err", 0, er);
    cmp("store55 req", 1, nws);
    cmp("store idx", 8'h37, nwi);
  endtask
  // protection codes and erase on leaving readback guard
  task automatic t_prot;
    logic [1:0] seq[7] = '{1, 3, 0, 3, 2, 1, 0};
    logic [1:0] pv;
    pv = 0;
    foreach (seq[i]) begin
      req(4'b0001, 8'h00, 8'h51, seq[i]);
      cmp("erase", pv[0] & ~seq[i][0], ers);
      cmp("prot", seq[i], prot_r);
      pv = seq[i];
    end
  endtask
  // read-only status, tick, random, bank 1
  task automatic t_stat;
    for (int s = 0; s < 4; s++) begin
      run_state_in = s[1:0];
      req(4'b0100, 8'h00, 8'h80);
      cmp("run state", s, rd);
    end
    req(4'b0001, 8'h00, 8'h80, 1);
    cmp("ro err", 1, er);
    req(4'b0100, 8'h00, 8'h82);
    cmp("pc", prog_pc_in, rd);
    req(4'b0100, 8'h01, 8'h00);
    cmp("bank1 err", 1, er);
    req(4'b0001, 8'h00, 8'h84, 32'hfffffff0);
    repeat (3 * TC) @(posedge core_clk);
    req(4'b0100, 8'h00, 8'h84);
    cmp("ms ticks", 1, (rd - 32'hfffffff0) inside {3, 4});
    for (int j = 0; j < 2; j++) begin
      ra = rd;
      req(4'b0001, 8'h00, 8'h85, 32'h1234);
      req(4'b0100, 8'h00, 8'h85);
    end
    cmp("reseed", ra, rd);
    cmp("rand top", 0, rd[31]);
  endtask
  // reply mute and second address
  task automatic t_mute;
    req(4'b0011, 8'h00, 8'hff, 1);
    req(4'b0011, 8'h00, 8'h57, 8'h12);
    cmp("muted", 0, sd);
    cmp("addr2 on", 1, addr2_en_r);
    req(4'b0110, 8'h00, 8'h57);
    cmp("get send", 1, sd);
    cmp("addr2", 8'h12, rd);
    req(4'b1010, 8'h00, 8'hff);
    cmp("mute store", 1, er);
    req(4'b0011, 8'h00, 8'h57, 0);
    cmp("addr2 off", 0, addr2_en_r);
  endtask
  // coordinate mirror and shaft reversal
  task automatic t_coord;
    logic hit;
    for (int m = 1; m >= 0; m--) begin
      req(4'b0001, 8'h00, 8'h54, m);
      cmp("coord persist", m, coord_persist_r);
      hit = 0;
      coord_wr_evt = 1;
      repeat (5) begin
        @(posedge core_clk) #1;
        coord_wr_evt = 0;
        hit |= nv_coord_wr_r === 1'b1;
      end
      cmp("coord mirror", m, hit);
    end
    req(4'b0001, 8'h00, 8'h5a, 1);
    cmp("reverse", 1, dir_invert_r);
    stepdir_mode = 1;
    @(posedge core_clk) #1;
    cmp("stepdir", 0, dir_invert_r);
  endtask
  // edge selects, priority, timers via bank 3
  task automatic t_irq;
    req(4'b0001, 8'h03, 8'h27, 1);
    req(4'b0001, 8'h03, 8'h28, 1);
    req(4'b0001, 8'h03, 8'h1b, 1);
    req(4'b0001, 8'h03, 8'h1c, 1);
    {stop_right_pin, stop_left_pin, gp_in_pin[1:0]} = 4'hf;
    drain(12);
    cmp("irq count", 4, nq.size());
    cmp("irq first", 27, nq[0]);
    cmp("irq second", 28, nq[1]);
    cmp("irq third", 39, nq[2]);
    cmp("irq fourth", 40, nq[3]);
    for (int m = 0; m < 4; m++) begin
      req(4'b0001, 8'h03, 8'h29, m);
      gp_in_pin[2] = 1;
      drain(10);
      cmp("rise irq", m[0], nq.size());
      gp_in_pin[2] = 0;
      drain(10);
      cmp("fall irq", m[1], nq.size());
    end
    for (int n = 0; n < 3; n++) begin
      req(4'b0001, 8'h03, n[7:0], 1);
      drain(2 * TC + TC / 2);
      cmp("timer irqs", 1, nq.size() inside {2, 3});
      cmp("timer num", n, nq[0]);
      req(4'b0001, 8'h03, n[7:0], 0);
      drain(5);
    end
    drain(3 * TC);
    cmp("timers off", 0, nq.size());
  endtask
  // restart with restore skipped
  task automatic t_reboot;
    int n0;
    n0 = nreq;
    skip = 1;
    @(posedge core_clk) #1 rst_n = 0;
    repeat (2) @(posedge core_clk);
    #1 rst_n = 1;
    wait_rdy(4);
    cmp("no restore", n0, nreq);
    cmp("skip out", 1, skip_restore_r);
    req(4'b0011, 8'h00, 8'h5a, 0);
    cmp("mute cleared", 1, sd);
    req(4'b0100, 8'h00, 8'h55);
    cmp("skip flag", 1, rd);
  endtask
  // main sequence
  initial begin
    repeat (2) @(posedge core_clk);
    #1 rst_n = 1;
    t_uvar;
    t_prot;
    t_stat;
    t_mute;
    t_coord;
    t_irq;
    t_reboot;
    stop_test;
  end
  // watchdog
  initial begin
    #(50 * 20000);
    mismatches++;
    stop_test;
  end
endmodule
`default_nettype wire
